// ---- ddc_frame.sv ----
// host port, serial clocking and multi-chip sync of the downconverter
`include "ddc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ddc_frame
  import ddc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic front_end_clock_i,
  input wire logic timing_reference_clock_i,
  input wire logic host_wr_n_i,
  input wire logic host_rd_n_i,
  input wire logic [2:0] host_addr_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  input wire logic serial_output_disable_i,
  input wire logic serial_lane_a_d_i,
  input wire logic serial_lane_b_d_i,
  output logic serial_lane_a_o,
  output logic serial_lane_b_o,
  output logic serial_bit_clock_o,
  output logic serial_word_strobe_o,
  output logic serial_oe_o,
  input wire logic multi_chip_sync_in_i,
  output logic multi_chip_sync_out_o,
  input wire logic front_sync_input_i,
  input wire logic back_sync_input_i,
  output logic sync_strobe_out_o,
  output logic cic_sync_o,
  output logic carrier_nco_sync_o,
  output logic fir_sync_o,
  output logic timing_nco_sync_o,
  output logic agc_sync_o,
  output logic timing_ref_tick_o
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic wr_n_s;
  logic rd_n_s;
  logic msi_s;
  logic fsi_s;
  logic bsi_s;
  logic ref_s;
  logic sod_s;
  logic front_toggle_reg;
  logic front_toggle_s;
  ddc_sync2 u_wr (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(host_wr_n_i), .q_o(wr_n_s));
  ddc_sync2 u_rd (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(host_rd_n_i), .q_o(rd_n_s));
  ddc_sync2 u_msi (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(multi_chip_sync_in_i), .q_o(msi_s));
  ddc_sync2 u_fsi (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(front_sync_input_i), .q_o(fsi_s));
  ddc_sync2 u_bsi (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(back_sync_input_i), .q_o(bsi_s));
  // timing reference sampled as a level; it is at most half clock_i
  ddc_sync2 u_ref (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(timing_reference_clock_i),
    .q_o(ref_s));
  ddc_sync2 u_sod (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(serial_output_disable_i),
    .q_o(sod_s));
  ddc_sync2 u_ftg (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(front_toggle_reg),
    .q_o(front_toggle_s));

  // ------------------------------------------------------------
  // front-end domain: toggle per front-end edge of the sync strobe
  // ------------------------------------------------------------
  logic front_toggle_next;
  logic stb_src_f1_reg;
  logic stb_src_f2_reg;
  logic stb_req_f1_reg;
  logic stb_req_f2_reg;
  logic stb_req_f3_reg;
  logic stb_src_reg;
  logic stb_req_reg;
  always_comb begin
    front_toggle_next = front_toggle_reg ^ (stb_req_f2_reg & ~stb_req_f3_reg & stb_src_f2_reg);
  end
  // front-end sections tick on front_end_clock_i rising edges
  always_ff @(posedge front_end_clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      front_toggle_reg <= 1'b0;
      stb_src_f1_reg <= 1'b0;
      stb_src_f2_reg <= 1'b0;
      stb_req_f1_reg <= 1'b0;
      stb_req_f2_reg <= 1'b0;
      stb_req_f3_reg <= 1'b0;
    end else begin
      front_toggle_reg <= front_toggle_next;
      stb_src_f1_reg <= stb_src_reg;
      stb_src_f2_reg <= stb_src_f1_reg;
      stb_req_f1_reg <= stb_req_reg;
      stb_req_f2_reg <= stb_req_f1_reg;
      stb_req_f3_reg <= stb_req_f2_reg;
    end
  end

  // ------------------------------------------------------------
  // back-end domain: control words, edges, strobes, serial clock
  // ------------------------------------------------------------
  ddc_byte_t ctrl0_reg, ctrl0_next;
  ddc_byte_t sync_en_reg, sync_en_next;
  ddc_byte_t ser_div_reg, ser_div_next;
  ddc_byte_t div_cnt_reg, div_cnt_next;
  logic ser_clk_reg, ser_clk_next;
  logic wr_d_reg, rd_d_reg, fsi_d_reg, bsi_d_reg, ref_d_reg, ftg_d_reg;
  logic stb_src_next, stb_req_next;
  logic [3:0] stb_cnt_reg, stb_cnt_next;
  ddc_byte_t rdata_reg, rdata_next;
  ddc_rd_state_e rd_state_reg, rd_state_next;
  logic msync_reg, msync_next;
  logic [4:0] pulse_reg, pulse_next;
  logic tick_reg, tick_next;
  logic wr_rise, rd_fall, fsi_rise, bsi_rise, ftg_evt;

  function automatic ddc_byte_t rd_mux(input logic [2:0] a, input ddc_byte_t c0,
      input ddc_byte_t se, input ddc_byte_t sd, input logic ms);
    case (a)
      `DDC_ADDR_CTRL0: rd_mux = c0;
      `DDC_ADDR_SYNC_EN: rd_mux = se;
      `DDC_ADDR_SER_DIV: rd_mux = sd;
      `DDC_ADDR_STROBE: rd_mux = {7'h00, ms};
      default: rd_mux = `DDC_STS_VERSION;
    endcase
  endfunction

  assign wr_rise = wr_n_s & ~wr_d_reg;
  assign rd_fall = ~rd_n_s & rd_d_reg;
  assign fsi_rise = fsi_s & ~fsi_d_reg;
  assign bsi_rise = bsi_s & ~bsi_d_reg;
  assign ftg_evt = front_toggle_s ^ ftg_d_reg;

  always_comb begin
    ctrl0_next = ctrl0_reg;
    sync_en_next = sync_en_reg;
    ser_div_next = ser_div_reg;
    stb_src_next = stb_src_reg;
    stb_req_next = stb_req_reg;
    stb_cnt_next = (stb_cnt_reg != 4'h0) ? stb_cnt_reg - 4'h1 : 4'h0;
    // crossing ack clears the request first so a write in the same cycle wins
    if (ftg_evt) begin
      stb_cnt_next = `DDC_STROBE_LEN;
      stb_req_next = 1'b0;
    end
    if (wr_rise) begin
      case (host_addr_i)
        `DDC_ADDR_CTRL0: ctrl0_next = host_data_i;
        `DDC_ADDR_SYNC_EN: sync_en_next = host_data_i;
        `DDC_ADDR_SER_DIV: ser_div_next = host_data_i;
        `DDC_ADDR_STROBE: begin
          // strobe timed from back-end clock or from front-end clock
          stb_src_next = ctrl0_reg[`DDC_C0_STB_SRC];
          stb_req_next = ctrl0_reg[`DDC_C0_STB_SRC];
          if (!ctrl0_reg[`DDC_C0_STB_SRC]) begin
            stb_cnt_next = `DDC_STROBE_LEN;
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    // bit clock toggles each ser_div+1 cycles of the back-end clock
    if (div_cnt_reg >= ser_div_reg) begin
      div_cnt_next = 8'h00;
      ser_clk_next = ~ser_clk_reg;
    end else begin
      div_cnt_next = div_cnt_reg + 8'h01;
      ser_clk_next = ser_clk_reg;
    end
    // multi-chip sync out is the front-end event moved into back-end domain
    msync_next = ftg_evt;
    // local sync pulses are qualified by the shared sync input
    pulse_next[0] = fsi_rise & msi_s & ctrl0_reg[`DDC_C0_CIC_EN];
    pulse_next[1] = fsi_rise & msi_s & ctrl0_reg[`DDC_C0_NCO_EN];
    pulse_next[2] = bsi_rise & msi_s & sync_en_reg[`DDC_SE_FIR];
    pulse_next[3] = bsi_rise & msi_s & sync_en_reg[`DDC_SE_TNCO];
    pulse_next[4] = bsi_rise & msi_s & sync_en_reg[`DDC_SE_AGC];
    tick_next = ref_s & ~ref_d_reg;
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    case (rd_state_reg)
      DDC_RD_IDLE: begin
        if (rd_fall) begin
          rd_state_next = DDC_RD_DRIVE;
          rdata_next = rd_mux(host_addr_i, ctrl0_reg, sync_en_reg, ser_div_reg, msync_reg);
        end
      end
      DDC_RD_DRIVE: begin
        if (rd_n_s) begin
          rd_state_next = DDC_RD_IDLE;
        end
      end
      default: rd_state_next = DDC_RD_IDLE;
    endcase
  end

  // back-end sections tick on clock_i rising edges
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl0_reg <= 8'h00;
      sync_en_reg <= 8'h00;
      ser_div_reg <= `DDC_SER_DIV_RST;
      div_cnt_reg <= 8'h00;
      ser_clk_reg <= 1'b0;
      wr_d_reg <= 1'b1;
      rd_d_reg <= 1'b1;
      fsi_d_reg <= 1'b0;
      bsi_d_reg <= 1'b0;
      ref_d_reg <= 1'b0;
      ftg_d_reg <= 1'b0;
      stb_src_reg <= 1'b0;
      stb_req_reg <= 1'b0;
      stb_cnt_reg <= 4'h0;
      rdata_reg <= 8'h00;
      rd_state_reg <= DDC_RD_IDLE;
      msync_reg <= 1'b0;
      pulse_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      ctrl0_reg <= ctrl0_next;
      sync_en_reg <= sync_en_next;
      ser_div_reg <= ser_div_next;
      div_cnt_reg <= div_cnt_next;
      ser_clk_reg <= ser_clk_next;
      wr_d_reg <= wr_n_s;
      rd_d_reg <= rd_n_s;
      fsi_d_reg <= fsi_s;
      bsi_d_reg <= bsi_s;
      ref_d_reg <= ref_s;
      ftg_d_reg <= front_toggle_s;
      stb_src_reg <= stb_src_next;
      stb_req_reg <= stb_req_next;
      stb_cnt_reg <= stb_cnt_next;
      rdata_reg <= rdata_next;
      rd_state_reg <= rd_state_next;
      msync_reg <= msync_next;
      pulse_reg <= pulse_next;
      tick_reg <= tick_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign host_data_o = rdata_reg;
  assign host_data_oe_o = (rd_state_reg == DDC_RD_DRIVE);
  assign serial_lane_a_o = serial_lane_a_d_i;
  assign serial_lane_b_o = serial_lane_b_d_i;
  assign serial_bit_clock_o = ser_clk_reg;
  assign serial_word_strobe_o = ser_clk_reg & (div_cnt_reg == 8'h00);
  assign serial_oe_o = ~sod_s;
  assign multi_chip_sync_out_o = msync_reg;
  assign sync_strobe_out_o = (stb_cnt_reg != 4'h0);
  assign cic_sync_o = pulse_reg[0];
  assign carrier_nco_sync_o = pulse_reg[1];
  assign fir_sync_o = pulse_reg[2];
  assign timing_nco_sync_o = pulse_reg[3];
  assign agc_sync_o = pulse_reg[4];
  assign timing_ref_tick_o = tick_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_wr_edge;
    wr_rise && host_addr_i == `DDC_ADDR_SER_DIV;
  endsequence
  property p_write;
    @(posedge clock_i) disable iff (!rstn_i) s_wr_edge |=> ser_div_reg == $past(host_data_i);
  endproperty
  a_write: assert property (p_write) else $error("write not stored");
  property p_read;
    @(posedge clock_i) disable iff (!rstn_i) rd_fall && rd_state_reg == DDC_RD_IDLE |=> host_data_oe_o;
  endproperty
  a_read: assert property (p_read) else $error("read not driven");
  property p_oe;
    @(posedge clock_i) disable iff (!rstn_i)
      $past(rstn_i, 2) |-> serial_oe_o == !$past(serial_output_disable_i, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("serial enable wrong");
  property p_fir;
    @(posedge clock_i) disable iff (!rstn_i) bsi_rise && msi_s && sync_en_reg[`DDC_SE_FIR] |=> fir_sync_o;
  endproperty
  a_fir: assert property (p_fir) else $error("fir sync missing");
  property p_cic;
    @(posedge clock_i) disable iff (!rstn_i) cic_sync_o |-> $past(fsi_rise);
  endproperty
  a_cic: assert property (p_cic) else $error("cic sync spurious");
  property p_msync;
    @(posedge clock_i) disable iff (!rstn_i) ftg_evt |=> multi_chip_sync_out_o;
  endproperty
  a_msync: assert property (p_msync) else $error("msync missing");
  property p_div;
    @(posedge clock_i) disable iff (!rstn_i) div_cnt_reg > ser_div_reg |=> div_cnt_reg == 8'h00;
  endproperty
  a_div: assert property (p_div) else $error("divider overrun");
  property p_stb;
    @(posedge clock_i) disable iff (!rstn_i) ftg_evt |=> sync_strobe_out_o [*4];
  endproperty
  a_stb: assert property (p_stb) else $error("strobe too short");
endmodule
`default_nettype wire

// ---- ddc_cfg.svh ----
// constants for the downconverter host, sync and clocking frame
// Contract
// - serial bit clock divides back-end clock
// - disable high floats serial lanes, clock, strobe
// - write strobe rise stores data at address
// - read strobe fall drives selected location
// - timing detector runs on reference clock
// - multi-chip sync carries front to back
// - front sync pulse aligns CIC and NCO
// - back sync pulse aligns FIR, NCO, AGC
// - host makes sync strobe, clock selectable
// - front-end sections run on front clock
// - back-end sections run on back clock
// - asynchronous clocks cross through synchronisers
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH
// ------------------------------------------------------------
// control word addresses
// ------------------------------------------------------------
`define DDC_ADDR_CTRL0 3'h0
`define DDC_ADDR_SYNC_EN 3'h1
`define DDC_ADDR_SER_DIV 3'h2
`define DDC_ADDR_STROBE 3'h3
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define DDC_C0_CIC_EN 0
`define DDC_C0_NCO_EN 1
`define DDC_C0_STB_SRC 2
`define DDC_SE_FIR 0
`define DDC_SE_TNCO 1
`define DDC_SE_AGC 2
`define DDC_SER_DIV_RST 8'h01
`define DDC_STROBE_LEN 4'h4
`define DDC_STS_VERSION 8'h5a
`endif

// ---- ddc_pkg.sv ----
// types for the downconverter host, sync and clocking frame
package ddc_pkg;
  typedef enum logic [1:0] {
    DDC_RD_IDLE,
    DDC_RD_DRIVE
  } ddc_rd_state_e;
  typedef logic [7:0] ddc_byte_t;
endpackage

// ---- ddc_sync2.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ddc_sync2 (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_reg;
  logic s2_reg;
  logic s1_next;
  logic s2_next;
  always_comb begin
    s1_next = d_i;
    s2_next = s1_reg;
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end
  assign q_o = s2_reg;
endmodule
`default_nettype wire

// ---- ddc_host_model.sv ----
// host processor and companion chip model for the downconverter frame
`timescale 1ns/1ps
`default_nettype none
module ddc_host_model (
  input wire logic clock_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_data_oe_i,
  output logic host_wr_n_o,
  output logic host_rd_n_o,
  output logic [2:0] host_addr_o,
  output logic [7:0] host_data_o,
  output logic timing_reference_clock_o,
  output logic multi_chip_sync_in_o
);
  logic [1:0] ref_div = 2'h0;
  initial begin
    host_wr_n_o = 1'b1;
    host_rd_n_o = 1'b1;
    host_addr_o = 3'h0;
    host_data_o = 8'h00;
    multi_chip_sync_in_o = 1'b1;
  end
  // reference runs at a quarter of the back-end clock
  always @(posedge clock_i) ref_div <= ref_div + 2'h1;
  assign timing_reference_clock_o = ref_div[1];
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    step(1);
    host_addr_o = a;
    host_data_o = d;
    host_wr_n_o = 1'b0;
    step(3);
    host_wr_n_o = 1'b1;
    step(5);
    host_data_o = ~d;
    host_addr_o = ~a;
  endtask
  task automatic hold_sync(input logic v);
    multi_chip_sync_in_o = v;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    step(1);
    host_addr_o = a;
    host_rd_n_o = 1'b0;
    for (n = 0; n < 12 && !ok; n++) begin
      step(1);
      ok = (host_data_oe_i === 1'b1);
      d = host_data_i;
    end
    step(3);
    host_rd_n_o = 1'b1;
    step(5);
    host_addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// ---- ddc_frame_tb_top.sv ----
// self-checking testbench of the downconverter frame
`include "ddc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ddc_frame_tb_top
  import ddc_pkg::*;
;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic fclk = 1'b0;
  logic dis = 1'b0;
  logic la = 1'b0;
  logic lb = 1'b0;
  logic fs = 1'b0;
  logic bs = 1'b0;
  logic [31:0] lfsr = 32'h68e6083a;
  wire logic wr_n, rd_n, refc, msi, hoe, sbc, soe, sla, slb, sws;
  wire logic [2:0] addr;
  wire logic [7:0] hdi, hdo, pv;
  int error_cnt = 0;
  int n_compared = 0;
  int cnt [8] = '{default: 0};
  always #20 clock_i = ~clock_i;
  always #17 fclk = ~fclk;
  always @(posedge clock_i) begin
    #1;
    la = ~la;
    lb = lfsr[3];
  end
  // pulses are counted mid-cycle, away from the launching edge
  always @(negedge clock_i) begin
    for (int k = 0; k < 8; k++) cnt[k] = cnt[k] + (pv[k] === 1'b1);
    chk({14'h0, sla, slb}, {14'h0, la, lb});
  end
  ddc_host_model ddc_host_model_i (.clock_i(clock_i), .host_data_i(hdo),
    .host_data_oe_i(hoe), .host_wr_n_o(wr_n), .host_rd_n_o(rd_n), .host_addr_o(addr),
    .host_data_o(hdi), .timing_reference_clock_o(refc), .multi_chip_sync_in_o(msi));
  ddc_frame ddc_frame_i (.clock_i(clock_i), .rstn_i(rstn_i), .front_end_clock_i(fclk),
    .timing_reference_clock_i(refc), .host_wr_n_i(wr_n), .host_rd_n_i(rd_n),
    .host_addr_i(addr), .host_data_i(hdi), .host_data_o(hdo), .host_data_oe_o(hoe),
    .serial_output_disable_i(dis), .serial_lane_a_d_i(la), .serial_lane_b_d_i(lb),
    .serial_lane_a_o(sla), .serial_lane_b_o(slb), .serial_bit_clock_o(sbc),
    .serial_word_strobe_o(sws), .serial_oe_o(soe), .multi_chip_sync_in_i(msi),
    .multi_chip_sync_out_o(pv[5]), .front_sync_input_i(fs), .back_sync_input_i(bs),
    .sync_strobe_out_o(pv[6]), .cic_sync_o(pv[0]), .carrier_nco_sync_o(pv[1]),
    .fir_sync_o(pv[2]), .timing_nco_sync_o(pv[3]), .agc_sync_o(pv[4]),
    .timing_ref_tick_o(pv[7]));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic int half_period(input logic [7:0] d);
    return int'(d) + 1;
  endfunction
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_lvl(input logic v);
    for (int n = 0; n < 600 && sbc !== v; n++) tick();
  endtask
  task automatic meas(output int h, output int w);
    h = 0;
    w = 0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    while (sbc === 1'b1 && h < 600) begin
      h++;
      w = w + (sws === 1'b1);
      tick();
    end
  endtask
  task automatic end_of_test();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    logic [7:0] r, d, m;
    logic ok;
    int h;
    int w;
    int s0 [8];
    repeat (3) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    repeat (3) tick();
    chk(16'(soe), 16'h1);
    for (int k = 0; k < 8; k++) begin
      if (k == 3) continue;
      r = rnd();
      ddc_host_model_i.wr(3'(k), r);
      ddc_host_model_i.rd(3'(k), d, ok);
      chk(16'(ok), 16'h1);
      chk(16'(d), 16'((k < 3) ? r : `DDC_STS_VERSION));
    end
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      if (k < 2) r = k ? 8'hff : 8'h00;
      ddc_host_model_i.wr(`DDC_ADDR_SER_DIV, r);
      meas(h, w);
      chk(16'(h), 16'(half_period(r)));
      chk(16'(w), 16'h1);
    end
    dis = 1'b1;
    repeat (3) tick();
    chk(16'(soe), 16'h0);
    dis = 1'b0;
    repeat (3) tick();
    chk(16'(soe), 16'h1);
    for (int k = 0; k < 6; k++) begin
      m = rnd();
      if (k < 3) m = (k == 1) ? 8'h00 : 8'h1f;
      // shared sync input low must block every local sync pulse
      ddc_host_model_i.hold_sync(k != 2);
      ddc_host_model_i.wr(`DDC_ADDR_CTRL0, {6'h0, m[1:0]});
      ddc_host_model_i.wr(`DDC_ADDR_SYNC_EN, {5'h0, m[4:2]});
      s0 = cnt;
      fs = 1'b1;
      bs = 1'b1;
      repeat (4) tick();
      fs = 1'b0;
      bs = 1'b0;
      repeat (20) tick();
      for (int j = 0; j < 5; j++) begin
        chk(16'(cnt[j] - s0[j]), 16'(m[j] & (k != 2)));
      end
    end
    for (int k = 0; k < 2; k++) begin
      ddc_host_model_i.wr(`DDC_ADDR_CTRL0, 8'(k << `DDC_C0_STB_SRC));
      s0 = cnt;
      ddc_host_model_i.wr(`DDC_ADDR_STROBE, 8'h01);
      repeat (20) tick();
      chk(16'(cnt[5] - s0[5]), 16'(k));
      chk(16'(cnt[6] - s0[6]), 16'(`DDC_STROBE_LEN));
    end
    s0 = cnt;
    repeat (40) tick();
    h = cnt[7] - s0[7];
    chk(16'(h >= 9 && h <= 11), 16'h1);
    end_of_test();
  end
  initial begin
    #800000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
